// ### core/pvs_cfg.svh
`ifndef PVS_CFG_SVH
`define PVS_CFG_SVH

// fixed upper address bits, sent first, then strap bit, then r/w bit
`define PVS_ADDR_FIXED 6'h0a
`define PVS_ADDR_FIXED_W 6
`define PVS_RW_WRITE 1'b0

// data byte field positions
`define PVS_SEL_BIT 5
`define PVS_CORE_MSB 4
`define PVS_SIM_MSB 1

// serial bit counter values
`define PVS_BITS_PER_BYTE 4'h8
`define PVS_ACK_SLOT 4'h8

// power-up settings: core code for 1.3V, sim code for 0V
`define PVS_CORE_RST 5'h18
`define PVS_SIM_RST 2'h0

// voltage scale in millivolts
`define PVS_CORE_BASE_MV 12'h2bc
`define PVS_CORE_STEP_MV 12'h019
`define PVS_SIM_MV_0 12'h000
`define PVS_SIM_MV_1 12'h708
`define PVS_SIM_MV_2 12'h9c4
`define PVS_SIM_MV_3 12'hbb8
`define PVS_CORE_MV_RST 12'h514

`endif

// ### core/pvs_pkg.sv
package pvs_pkg;
    // link-side transfer phase
    typedef enum logic [1:0] {
        PVS_IDLE = 2'b00,
        PVS_ADDR = 2'b01,
        PVS_DATA = 2'b10,
        PVS_DONE = 2'b11
    } pvs_phase_e;

    typedef logic [4:0] pvs_core_code_t;
    typedef logic [1:0] pvs_sim_code_t;
    typedef logic [11:0] pvs_mv_t;
endpackage : pvs_pkg

// ### core/pvs_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "pvs_cfg.svh"

// Behaviour
// (RULE1) acknowledge address and data bytes by holding data low through ninth clock
// (RULE2) master retries later when no acknowledge is seen
// (RULE3) idle device waits for start followed by its own address
// (RULE4) address compared bit by bit, first mismatch drops the transfer
// (RULE5) upper address bits fixed 001010, next bit follows strap pin
// (RULE6) last address bit is read/write, only writes (0) accepted
// (RULE7) core code maps to 0.7V plus 25mV per step up to 1.475V
// (RULE8) sim code maps to 0V, 1.8V, 2.5V or 3.0V
// (RULE9) backup rail follows io supply when enabled and regulating, else battery
// (RULE10) data bit 5 picks core or sim, low bits carry the code
// (RULE11) core starts at 1.3V, sim at 0V until written
// (RULE12) after stop or mismatch, serial clock ignored until next start
// (RULE13) data applied only after full byte received and acknowledged
module pvs_slave
    import pvs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic address_select_strap,
    input wire logic io_converter_enable,
    input wire logic io_supply_in_regulation,
    output logic [4:0] core_supply_output,
    output logic [11:0] core_supply_mv,
    output logic [1:0] sim_supply_output,
    output logic [11:0] sim_supply_mv,
    output logic backup_rail_output
);
    // expected address bit for serial position idx (0 is sent first)
    function automatic logic exp_addr_bit(input logic [3:0] idx, input logic strap);
        logic [7:0] pattern;
        pattern = {`PVS_ADDR_FIXED, strap, `PVS_RW_WRITE};
        exp_addr_bit = pattern[3'(4'h7 - idx)];
    endfunction : exp_addr_bit

    // core code to millivolts
    function automatic pvs_mv_t core_mv(input pvs_core_code_t code);
        logic [11:0] step;
        step = 12'(code) * `PVS_CORE_STEP_MV;
        core_mv = `PVS_CORE_BASE_MV + step;
    endfunction : core_mv

    // sim code to millivolts
    function automatic pvs_mv_t sim_mv(input pvs_sim_code_t code);
        case (code)
            2'h0: sim_mv = `PVS_SIM_MV_0;
            2'h1: sim_mv = `PVS_SIM_MV_1;
            2'h2: sim_mv = `PVS_SIM_MV_2;
            default: sim_mv = `PVS_SIM_MV_3;
        endcase
    endfunction : sim_mv

    logic start_tgl_q;
    logic stop_tgl_q;
    // start: data falls while clock high
    always_ff @(negedge sda_i or negedge rstn)
    begin
        if (!rstn)
            start_tgl_q <= 1'b0;
        else if (scl)
            start_tgl_q <= ~start_tgl_q;
    end

    // stop: data rises while clock high
    always_ff @(posedge sda_i or negedge rstn)
    begin
        if (!rstn)
            stop_tgl_q <= 1'b0;
        else if (scl)
            stop_tgl_q <= ~stop_tgl_q;
    end

    logic start_seen_q;
    logic stop_seen_q;
    logic strap_s1_q;
    logic strap_s2_q;
    pvs_phase_e phase_q;
    pvs_phase_e phase_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shift_q;
    logic [5:0] word_q;
    logic upd_tgl_q;
    logic ack_oe_q;
    logic sda_o_q;
    // start/stop toggles differ from last seen copy
    wire start_hit = start_tgl_q != start_seen_q;
    wire stop_hit = stop_tgl_q != stop_seen_q;
    wire addr_bit_ok = sda_i == exp_addr_bit(cnt_q, strap_s2_q);
    wire first_bit_ok = sda_i == exp_addr_bit(4'h0, strap_s2_q);
    wire in_ack = cnt_q == `PVS_ACK_SLOT;
    wire [7:0] data_byte = shift_q;
    // next phase and bit count
    always_comb
    begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        if (start_hit)
        begin
            cnt_d = 4'h1; // this edge already carries the first address bit
            phase_d = first_bit_ok ? PVS_ADDR : PVS_IDLE; // RULE3 RULE4
        end
        else if (stop_hit)
        begin
            phase_d = PVS_IDLE; // RULE12
            cnt_d = 4'h0;
        end
        else
        begin
            case (phase_q)
                PVS_ADDR:
                begin
                    if (in_ack)
                    begin
                        phase_d = PVS_DATA;
                        cnt_d = 4'h0;
                    end
                    else if (addr_bit_ok) // RULE4 RULE5 RULE6
                        cnt_d = cnt_q + 4'h1;
                    else
                        phase_d = PVS_IDLE; // RULE12
                end
                PVS_DATA:
                begin
                    if (in_ack)
                        phase_d = PVS_DONE; // one send byte only
                    else
                        cnt_d = cnt_q + 4'h1;
                end
                default: phase_d = phase_q; // RULE12
            endcase
        end
    end

    // strap crosses into serial clock domain
    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end
        else
        begin
            strap_s1_q <= address_select_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // sample data bits on rising clock
    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
            phase_q <= PVS_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
        end
        else
        begin
            start_seen_q <= start_tgl_q;
            stop_seen_q <= stop_tgl_q;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            if (phase_q == PVS_DATA && !in_ack)
                shift_q <= {shift_q[6:0], sda_i};
        end
    end

    // latch command word once its acknowledge clock is sampled
    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            word_q <= 6'h00;
            upd_tgl_q <= 1'b0;
        end
        else if (!start_hit && !stop_hit && phase_q == PVS_DATA && in_ack)
        begin
            word_q <= data_byte[5:0]; // RULE13
            upd_tgl_q <= ~upd_tgl_q;
        end
    end

    // drive acknowledge from fall after bit 8 to fall after ninth clock
    always_ff @(negedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_oe_q <= 1'b0;
            sda_o_q <= 1'b0;
        end
        else
        begin
            ack_oe_q <= (phase_q == PVS_ADDR || phase_q == PVS_DATA) && in_ack; // RULE1
            sda_o_q <= 1'b0;
        end
    end

    assign sda_oe = ack_oe_q;
    assign sda_o = sda_o_q;

    logic upd_s1_q;
    logic upd_s2_q;
    logic upd_s3_q;
    logic en_s1_q;
    logic en_s2_q;
    logic reg_s1_q;
    logic reg_s2_q;
    logic [4:0] core_q;
    logic [11:0] core_mv_q;
    logic [1:0] sim_q;
    logic [11:0] sim_mv_q;
    logic bk_q;
    // word is stable before its toggle arrives
    wire upd_evt = upd_s2_q != upd_s3_q;
    wire sel_sim = word_q[`PVS_SEL_BIT]; // RULE10
    wire [4:0] new_core = word_q[`PVS_CORE_MSB:0];
    wire [1:0] new_sim = word_q[`PVS_SIM_MSB:0];
    // synchronisers for update toggle and io pins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            upd_s1_q <= 1'b0;
            upd_s2_q <= 1'b0;
            upd_s3_q <= 1'b0;
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            reg_s1_q <= 1'b0;
            reg_s2_q <= 1'b0;
        end
        else if (ce)
        begin
            upd_s1_q <= upd_tgl_q;
            upd_s2_q <= upd_s1_q;
            upd_s3_q <= upd_s2_q;
            en_s1_q <= io_converter_enable;
            en_s2_q <= en_s1_q;
            reg_s1_q <= io_supply_in_regulation;
            reg_s2_q <= reg_s1_q;
        end
    end

    // supply settings, power-up defaults
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core_q <= `PVS_CORE_RST; // RULE11
            sim_q <= `PVS_SIM_RST; // RULE11
        end
        else if (ce && upd_evt)
        begin
            if (sel_sim)
                sim_q <= new_sim; // RULE10
            else
                core_q <= new_core; // RULE10
        end
    end

    // voltage decode and backup rail source
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core_mv_q <= `PVS_CORE_MV_RST;
            sim_mv_q <= `PVS_SIM_MV_0;
            bk_q <= 1'b0;
        end
        else if (ce)
        begin
            core_mv_q <= core_mv(core_q); // RULE7
            sim_mv_q <= sim_mv(sim_q); // RULE8
            bk_q <= en_s2_q && reg_s2_q; // RULE9
        end
    end

    assign core_supply_output = core_q;
    assign core_supply_mv = core_mv_q;
    assign sim_supply_output = sim_q;
    assign sim_supply_mv = sim_mv_q;
    assign backup_rail_output = bk_q;

endmodule : pvs_slave
`default_nettype wire

// ### dv/pvs_master.sv
`timescale 1ns/10ps
`default_nettype none
// two-wire bus master, data line pulled up, clock driven high and low
module pvs_master (
    output logic scl,
    output wire logic sda,
    input wire logic sda_o,
    input wire logic sda_oe
);
    logic drv = 1'b1;
    int lo = 12;
    // open-drain wire, released level is high
    assign sda = drv && (!sda_oe || sda_o);
    initial scl = 1'b1;
    // data moves while the clock is low
    task automatic bit_x(input logic b, output logic got);
        drv = b;
        #lo;
        scl = 1'b1;
        #24;
        got = sda;
        scl = 1'b0;
        #12;
    endtask : bit_x
    // byte msb first, then the ack slot
    task automatic send(input logic [7:0] v, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_x(v[i], g);
        bit_x(1'b1, g);
        ack = !g;
    endtask : send
    task automatic start();
        drv = 1'b1;
        #12;
        scl = 1'b1;
        #12;
        drv = 1'b0;
        #12;
        scl = 1'b0;
    endtask : start
    task automatic stop();
        drv = 1'b0;
        #12;
        scl = 1'b1;
        #12;
        drv = 1'b1;
        #12;
    endtask : stop
endmodule : pvs_master
`default_nettype wire

// ### dv/pvs_slave_checker.sv
`timescale 1ns/10ps
`default_nettype none
// pin-level checks of ack, decode and rail source
module pvs_slave_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic io_converter_enable,
    input wire logic io_supply_in_regulation,
    input wire logic [4:0] core_supply_output,
    input wire logic [11:0] core_supply_mv,
    input wire logic [1:0] sim_supply_output,
    input wire logic [11:0] sim_supply_mv,
    input wire logic backup_rail_output
);
    // io supply usable or not for four clocks
    sequence s_io_up;
        (ce && io_converter_enable && io_supply_in_regulation)[*4];
    endsequence
    sequence s_io_down;
        (ce && !(io_converter_enable && io_supply_in_regulation))[*4];
    endsequence
    property p_ack_one;
        @(negedge scl) disable iff (!rstn) $rose(sda_oe) |=> !sda_oe;
    endproperty
    property p_ack_low;
        @(posedge scl) disable iff (!rstn) sda_oe |-> !sda_o;
    endproperty
    property p_core_mv;
        @(posedge clk) disable iff (!rstn) ce |=> core_supply_mv == 12'h2bc + 12'h019 * 12'($past(core_supply_output));
    endproperty
    property p_sim_mv;
        @(posedge clk) disable iff (!rstn) ce |=> sim_supply_mv == ($past(sim_supply_output) == 2'h0 ? 12'h000 :
            $past(sim_supply_output) == 2'h1 ? 12'h708 : $past(sim_supply_output) == 2'h2 ? 12'h9c4 : 12'hbb8);
    endproperty
    property p_bk_on;
        @(posedge clk) disable iff (!rstn) s_io_up |-> backup_rail_output;
    endproperty
    property p_bk_off;
        @(posedge clk) disable iff (!rstn) s_io_down |-> !backup_rail_output;
    endproperty
    property p_one_target;
        @(posedge clk) disable iff (!rstn) $changed(core_supply_output) |-> $stable(sim_supply_output);
    endproperty
    property p_power_up;
        @(posedge clk) $rose(rstn) |-> core_supply_output == 5'h18 && sim_supply_output == 2'h0;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one period");
    a_ack_low: assert property (p_ack_low) else $error("ack not low");
    a_core_mv: assert property (p_core_mv) else $error("core mv wrong");
    a_sim_mv: assert property (p_sim_mv) else $error("sim mv wrong");
    a_bk_on: assert property (p_bk_on) else $error("rail not from io");
    a_bk_off: assert property (p_bk_off) else $error("rail not from battery");
    a_one_target: assert property (p_one_target) else $error("both codes moved");
    a_power_up: assert property (p_power_up) else $error("bad power-up codes");
endmodule : pvs_slave_checker
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rstn = 1'b1, ce = 1'b1, strap = 1'b0, io_en = 1'b0, io_ok = 1'b0;
    wire logic scl, sda, sda_o, sda_oe, backup;
    wire logic [4:0] core;
    wire logic [1:0] sim;
    wire logic [11:0] core_mv, sim_mv;
    int fails = 0, num_checks = 0;
    always #25 clk = ~clk;
    pvs_master m (.scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    pvs_slave dut (.clk(clk), .rstn(rstn), .ce(ce), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_select_strap(strap), .io_converter_enable(io_en), .io_supply_in_regulation(io_ok),
        .core_supply_output(core), .core_supply_mv(core_mv), .sim_supply_output(sim), .sim_supply_mv(sim_mv),
        .backup_rail_output(backup));
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // framed write, acks compared, then the apply path settles
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic ea, input logic ed);
        logic ack;
        m.start();
        m.send(a, ack);
        chk("addr ack", 12'(ea), 12'(ack));
        m.send(d, ack);
        chk("data ack", 12'(ed), 12'(ack));
        m.stop();
        repeat (6) @(posedge clk);
        #2;
    endtask : xfer
    task automatic t_core();
        logic [4:0] c [3] = '{5'h00, 5'h1f, 5'h0d};
        foreach (c[i])
        begin
            xfer(8'h28, {3'b110, c[i]}, 1'b1, 1'b1);
            chk("core", 12'(c[i]), 12'(core));
            chk("core mv", 12'h2bc + 12'h019 * 12'(c[i]), core_mv);
        end
    endtask : t_core
    task automatic t_sim();
        logic [11:0] mv [4] = '{12'h000, 12'h708, 12'h9c4, 12'hbb8};
        for (int k = 0; k < 4; k++)
        begin
            xfer(8'h28, {6'h0f, 2'(k)}, 1'b1, 1'b1);
            chk("sim mv", mv[k], sim_mv);
            chk("sim", 12'(k), 12'(sim));
            chk("core", 12'h00d, 12'(core));
        end
    endtask : t_sim
    task automatic t_addr();
        xfer(8'h38, 8'h01, 1'b0, 1'b0);
        xfer(8'h29, 8'h01, 1'b0, 1'b0);
        xfer(8'h2a, 8'h01, 1'b0, 1'b0);
        chk("core", 12'h00d, 12'(core));
        strap = 1'b1;
        xfer(8'h2a, 8'h01, 1'b1, 1'b1);
        chk("core", 12'h001, 12'(core));
    endtask : t_addr
    task automatic t_rail();
        logic [1:0] p [4] = '{2'b11, 2'b01, 2'b11, 2'b10};
        foreach (p[i])
        begin
            @(posedge clk);
            #2 {io_en, io_ok} = p[i];
            repeat (4) @(posedge clk);
            #2;
            chk("rail", 12'(p[i] == 2'b11), 12'(backup));
        end
    endtask : t_rail
    // clock enable low holds the settings, link side still answers
    task automatic t_ce();
        @(posedge clk);
        #2 ce = 1'b0;
        xfer(8'h2a, 8'h05, 1'b1, 1'b1);
        chk("core", 12'h001, 12'(core));
        ce = 1'b1;
        repeat (5) @(posedge clk);
        #2;
        chk("core", 12'h005, 12'(core));
        chk("core mv", 12'h2bc + 12'h019 * 12'h005, core_mv);
    endtask : t_ce
    // reset in mid-run brings back the power-up settings
    task automatic t_reset();
        @(posedge clk);
        #2 rstn = 1'b0;
        repeat (2) @(posedge clk);
        #2 rstn = 1'b1;
        chk("core", 12'h018, 12'(core));
        chk("sim", 12'h000, 12'(sim));
        chk("core mv", 12'h514, core_mv);
    endtask : t_reset
    task automatic summarize();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // main sequence after a two-cycle reset
    initial
    begin
        #2 rstn = 1'b0;
        repeat (2) @(posedge clk);
        #2 rstn = 1'b1;
        chk("core", 12'h018, 12'(core));
        chk("sim", 12'h000, 12'(sim));
        t_core();
        t_sim();
        t_addr();
        t_ce();
        t_reset();
        t_rail();
        summarize();
    end
    // watchdog against a hung transfer
    initial
    begin
        #200000;
        fails++;
        summarize();
    end
endmodule : testbench
bind pvs_slave pvs_slave_checker u_chk (.clk(clk), .rstn(rstn), .ce(ce), .scl(scl), .sda_o(sda_o),
    .sda_oe(sda_oe), .io_converter_enable(io_converter_enable), .io_supply_in_regulation(io_supply_in_regulation),
    .core_supply_output(core_supply_output), .core_supply_mv(core_supply_mv), .sim_supply_output(sim_supply_output),
    .sim_supply_mv(sim_supply_mv), .backup_rail_output(backup_rail_output));
`default_nettype wire
